// ==== common/edrf_pkg.sv ====
// constants and carrier types for the event data return framer
`default_nettype none

package edrf_pkg;

    // ==================================================================
    // event buffering
    // ==================================================================
    localparam int unsigned NUM_BUF   = 4;       // event buffer levels
    localparam int unsigned PTR_W     = 2;       // buffer pointer width
    localparam int unsigned CNT_W     = 3;       // occupancy count width
    localparam int unsigned MAX_HITS  = 4;       // hit words held per event
    localparam int unsigned HCNT_W    = 3;       // hit count width (0..4)

    // ==================================================================
    // frame layout (every part a whole number of 32-bit words)
    // ==================================================================
    localparam int unsigned WORD_W    = 32;      // header, hit and trailer word
    localparam int unsigned BIT_W     = 5;       // bit index within a word
    localparam logic [4:0]  LAST_BIT  = 5'h1f;   // last bit of a word
    localparam logic [31:0] TRAILER   = 32'h0000_0000; // 32 zero bits
    localparam logic        START_BIT = 1'b1;    // first header bit
    localparam logic        TYPE_EVT  = 1'b1;    // event data
    localparam logic        TYPE_REG  = 1'b0;    // register read-back
    localparam logic [2:0]  RB_WORDS  = 3'h2;    // 64 register bits, 2 words
    localparam int unsigned REG_W     = 64;      // read-back register width

    // header word, bit 0 goes out first
    typedef struct packed {
        logic [7:0] spare;     // buffer index and occupancy
        logic [7:0] serial;    // section serial number
        logic [2:0] err;       // error code
        logic [4:0] time_f;    // trigger time or received address
        logic       rsvd;      // byte alignment, zero
        logic [4:0] tag_f;     // trigger tag or command code
        logic       kind;      // 1 event, 0 register
        logic       start;     // always one
    } edrf_hdr_t;

    // one stored event
    typedef struct packed {
        logic [4:0]                     tag;    // trigger tag
        logic [4:0]                     ttime;  // timing counter state
        logic [HCNT_W-1:0]              nhits;  // hit words used
        logic [MAX_HITS-1:0][WORD_W-1:0] hits;  // hit words, index 0 first
    } edrf_event_t;

    // read-back request
    typedef struct packed {
        logic [4:0]       opcode;  // received command code
        logic [4:0]       addr;    // received address
        logic [REG_W-1:0] value;   // register contents
    } edrf_rb_t;

    // transmitter states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR  = 2'b01,
        ST_DATA = 2'b10,
        ST_TAIL = 2'b11
    } edrf_state_t;

endpackage

`default_nettype wire

// ==== hdl/edrf_framer.sv ====
// front-end section return link framer: event buffers and serial frame sender
`timescale 1ns/1ps
`default_nettype none

module edrf_framer
(
    input  wire logic                 mclk_in,       // 125 MHz clock
    input  wire logic                 reset_in,      // sync reset, high
    input  wire logic                 bit_tick_in,   // one pulse per link bit
    input  wire logic                 frame_slot_in, // shared frame start slot
    input  wire logic                 trig_in,       // trigger accept pulse
    input  wire edrf_pkg::edrf_event_t event_in,     // event captured on trig_in
    input  wire logic                 read_in,       // read-event pulse
    input  wire logic                 clear_in,      // clear-readout pulse
    input  wire logic                 rb_req_in,     // read-back request pulse
    input  wire edrf_pkg::edrf_rb_t    rb_in,        // read-back contents
    input  wire logic [2:0]           err_in,        // error code for headers
    input  wire logic [7:0]           serial_in,     // section serial number
    output logic                      line_out,      // serial return data bit
    output logic                      busy_out,      // frame in progress
    output logic [2:0]                occupancy_out, // buffers holding events
    output logic                      full_out,      // all buffers occupied
    output logic                      pending_out    // a request awaits a slot
);
    import edrf_pkg::*;

    // ==================================================================
    // storage and state
    // ==================================================================
    edrf_event_t            buf_mem [NUM_BUF];  // event buffer levels
    logic [PTR_W-1:0]       wr_ptr_q;           // next free level
    logic [PTR_W-1:0]       rd_ptr_q;           // oldest unread level
    logic [CNT_W-1:0]       cnt_q;              // levels in use
    logic                   rd_pend_q;          // read-event waiting
    logic                   rb_pend_q;          // read-back waiting
    edrf_rb_t               rb_q;               // held read-back request
    edrf_state_t            state_q;            // transmitter state
    logic [WORD_W-1:0]      word_q;             // word being shifted
    logic [BIT_W-1:0]       bit_q;              // next bit index
    logic [MAX_HITS-1:0][WORD_W-1:0] data_q;    // data words of frame
    logic [HCNT_W-1:0]      nwords_q;           // data words in frame
    logic [HCNT_W-1:0]      widx_q;             // current data word
    logic                   var_q;              // variable length frame
    logic                   line_q;             // registered line bit

    logic                   store;              // event written this cycle
    logic                   start;              // frame starts this cycle
    logic                   start_evt;          // started frame is an event
    logic                   pop;                // oldest buffer leaves
    logic                   word_end;           // last bit of word sent
    edrf_event_t            head_evt;           // oldest buffered event
    edrf_hdr_t              hdr;                // header for starting frame

    // ==================================================================
    // helpers
    // ==================================================================
    // picks a data word by index, zero beyond the table
    function automatic logic [WORD_W-1:0] pick_word
    (
        input logic [MAX_HITS-1:0][WORD_W-1:0] words,
        input logic [HCNT_W-1:0]               idx
    );
        logic [WORD_W-1:0] w;
        w = '0;
        for (int i = 0; i < MAX_HITS; i++)
        begin
            if (idx == HCNT_W'(i))
            begin
                w = words[i];
            end
        end
        return w;
    endfunction

    // ==================================================================
    // control decode
    // ==================================================================
    // a full buffer drops the event; the far end's model prevents it
    assign store     = trig_in && (cnt_q != CNT_W'(NUM_BUF));
    assign head_evt  = buf_mem[rd_ptr_q];
    // start only on a shared slot so every section's start bit lines up
    assign start     = (state_q == ST_IDLE) && frame_slot_in && bit_tick_in
                       && (rd_pend_q || rb_pend_q);
    // event reads go ahead of read-back when both wait
    assign start_evt = rd_pend_q;
    assign pop       = start && start_evt;
    assign word_end  = bit_tick_in && (state_q != ST_IDLE) && (bit_q == LAST_BIT);

    // header build, shared field slots change meaning by frame kind
    always_comb
    begin
        hdr        = '0;
        hdr.start  = START_BIT;
        hdr.rsvd   = 1'b0;
        hdr.err    = err_in;
        hdr.serial = serial_in;
        if (start_evt)
        begin
            hdr.kind   = TYPE_EVT;
            hdr.tag_f  = head_evt.tag;
            hdr.time_f = head_evt.ttime;
            // low bits: source level, high bits: levels full
            hdr.spare  = {3'h0, cnt_q, 2'(rd_ptr_q)};
        end
        else
        begin
            hdr.kind   = TYPE_REG;
            hdr.tag_f  = rb_q.opcode;
            hdr.time_f = rb_q.addr;
            hdr.spare  = {3'h0, cnt_q, 2'h0};
        end
    end

    // ==================================================================
    // event buffer write
    // ==================================================================
    // tag, time and hits land together in one level
    always_ff @(posedge mclk_in)
    begin
        if (store)
        begin
            buf_mem[wr_ptr_q] <= event_in;
        end
    end

    // ==================================================================
    // buffer pointers and occupancy
    // ==================================================================
    // a trigger with a clear is counted, but its event lands at the old wr_ptr_q level while reads restart at level 0
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end
        else if (clear_in)
        begin
            rd_ptr_q <= '0;
            wr_ptr_q <= store ? PTR_W'(1) : '0;
            cnt_q    <= store ? CNT_W'(1) : '0;
        end
        else
        begin
            if (store)
            begin
                wr_ptr_q <= wr_ptr_q + PTR_W'(1);
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + PTR_W'(1);
            end
            cnt_q <= cnt_q + CNT_W'(store) - CNT_W'(pop);
        end
    end

    // ==================================================================
    // request holding
    // ==================================================================
    // read with nothing left after this cycle's pop is dropped, line stays at zeros
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            rd_pend_q <= 1'b0;
        end
        else if (clear_in)
        begin
            rd_pend_q <= 1'b0;
        end
        else if (read_in && (cnt_q != CNT_W'(pop)))
        begin
            rd_pend_q <= 1'b1;
        end
        else if (pop)
        begin
            rd_pend_q <= 1'b0;
        end
    end

    // read-back request held until its slot comes
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            rb_pend_q <= 1'b0;
            rb_q      <= '0;
        end
        else if (rb_req_in)
        begin
            rb_pend_q <= 1'b1;
            rb_q      <= rb_in;
        end
        else if (start && !start_evt)
        begin
            rb_pend_q <= 1'b0;
        end
    end

    // ==================================================================
    // frame sequencer
    // ==================================================================
    // walks header, data words and, for event frames only, trailer one word at a time
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            state_q  <= ST_IDLE;
            word_q   <= '0;
            data_q   <= '0;
            nwords_q <= '0;
            widx_q   <= '0;
            var_q    <= 1'b0;
        end
        else if (start)
        begin
            state_q <= ST_HDR;
            word_q  <= hdr;
            widx_q  <= '0;
            if (start_evt)
            begin
                var_q    <= 1'b1;
                data_q   <= head_evt.hits;
                nwords_q <= head_evt.nhits;
            end
            else
            begin
                // register bits go low word first, each lsb first
                var_q    <= 1'b0;
                data_q   <= {{(MAX_HITS*WORD_W-REG_W){1'b0}}, rb_q.value};
                nwords_q <= RB_WORDS;
            end
        end
        else if (word_end)
        begin
            case (state_q)
                ST_HDR:
                begin
                    if (nwords_q != '0)
                    begin
                        state_q <= ST_DATA;
                        word_q  <= pick_word(data_q, '0);
                    end
                    else if (var_q)
                    begin
                        state_q <= ST_TAIL;
                        word_q  <= TRAILER;
                    end
                    else
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_DATA:
                begin
                    if (widx_q + HCNT_W'(1) != nwords_q)
                    begin
                        widx_q <= widx_q + HCNT_W'(1);
                        word_q <= pick_word(data_q, widx_q + HCNT_W'(1));
                    end
                    else if (var_q)
                    begin
                        state_q <= ST_TAIL;
                        word_q  <= TRAILER;
                    end
                    else
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_TAIL:
                begin
                    state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==================================================================
    // bit counter
    // ==================================================================
    // wraps after bit 31, so each word is exactly 32 bits
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            bit_q <= '0;
        end
        else if (start)
        begin
            bit_q <= BIT_W'(1);
        end
        else if (bit_tick_in && (state_q != ST_IDLE))
        begin
            bit_q <= bit_q + BIT_W'(1);
        end
    end

    // ==================================================================
    // serial line
    // ==================================================================
    // changes only on bit ticks; zeros from the first idle tick until a frame starts
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            line_q <= 1'b0;
        end
        else if (start)
        begin
            line_q <= START_BIT;
        end
        else if (bit_tick_in)
        begin
            if (state_q != ST_IDLE)
            begin
                line_q <= word_q[bit_q];
            end
            else
            begin
                line_q <= 1'b0;
            end
        end
    end

    // ==================================================================
    // outputs
    // ==================================================================
    assign line_out      = line_q;
    assign busy_out      = (state_q != ST_IDLE);
    assign occupancy_out = cnt_q;
    assign full_out      = (cnt_q == CNT_W'(NUM_BUF));
    assign pending_out   = rd_pend_q || rb_pend_q;

endmodule

`default_nettype wire

// ==== tb/edrf_framer_checker.sv ====
// port-level assertion checker for the return link framer
`timescale 1ns/1ps
`default_nettype none
module edrf_framer_checker
(
    input  wire logic       mclk_in,       // clock
    input  wire logic       reset_in,      // sync reset
    input  wire logic       bit_tick_in,   // link bit pulse
    input  wire logic       frame_slot_in, // shared frame slot
    input  wire logic       trig_in,       // trigger accept
    input  wire logic       read_in,       // read-event
    input  wire logic       clear_in,      // clear-readout
    input  wire logic       rb_req_in,     // read-back request
    input  wire logic       line_out,      // serial bit
    input  wire logic       busy_out,      // frame running
    input  wire logic [2:0] occupancy_out, // buffered events
    input  wire logic       full_out,      // all buffers held
    input  wire logic       pending_out    // request waiting
);
    logic [9:0] bidx_q; // index of the bit now on the line
    logic       go;     // a frame starts at this edge
    assign go = !busy_out && frame_slot_in && bit_tick_in && pending_out;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    // ==========
    // bit counter, restarted on the start edge
    // ==========
    always_ff @(posedge mclk_in)
    begin
        if (reset_in || go)
        begin
            bidx_q <= 10'h0;
        end
        else if (bit_tick_in)
        begin
            bidx_q <= bidx_q + 10'h1;
        end
    end
    sequence s_launch;
        go ##1 busy_out;
    endsequence
    // the last frame bit stands until the first idle tick, so wait for that tick
    sequence s_quiet;
        (!busy_out && bit_tick_in) ##1 !busy_out;
    endsequence
    // ==========
    // line framing
    // ==========
    a_start_cause: assert property ($rose(busy_out) |-> $past(go))
        else $error("frame began without slot, tick and request");
    a_launch_bit: assert property (s_launch |-> line_out && bidx_q == 10'h0)
        else $error("first frame bit not one");
    a_hdr_zero: assert property (busy_out && (bidx_q == 10'h7 || (bidx_q >= 10'h1d
        && bidx_q <= 10'h1f)) |-> !line_out) else $error("reserved header bit set");
    a_frame_bound: assert property (busy_out |-> bidx_q <= 10'hbf)
        else $error("frame longer than six words");
    a_line_steady: assert property (!bit_tick_in |=> $stable(line_out))
        else $error("line moved without a bit tick");
    a_idle_low: assert property (s_quiet |-> !line_out)
        else $error("line high while idle");
    a_no_unasked: assert property (!pending_out && !busy_out |=> !busy_out)
        else $error("frame without request");
    // ==========
    // buffer bookkeeping
    // ==========
    a_empty_read: assert property (read_in && occupancy_out == 3'h0 && !pending_out
        && !rb_req_in |=> !pending_out) else $error("read of empty buffers kept");
    a_trig_fills: assert property (trig_in && !full_out && !clear_in && !go
        |=> occupancy_out == $past(occupancy_out) + 3'h1) else $error("trigger not stored");
    a_full_drop: assert property (trig_in && full_out && !clear_in && !go
        |=> occupancy_out == 3'h4) else $error("occupancy moved when full");
    a_clear_empty: assert property (clear_in && !trig_in |=> occupancy_out == 3'h0)
        else $error("clear left events");
endmodule
bind edrf_framer edrf_framer_checker u_chk (.mclk_in(mclk_in), .reset_in(reset_in),
    .bit_tick_in(bit_tick_in), .frame_slot_in(frame_slot_in), .trig_in(trig_in),
    .read_in(read_in), .clear_in(clear_in), .rb_req_in(rb_req_in), .line_out(line_out),
    .busy_out(busy_out), .occupancy_out(occupancy_out), .full_out(full_out),
    .pending_out(pending_out));
`default_nettype wire

// ==== tb/edrf_rx_model.sv ====
// readout-side receiver model that frames the serial return line
`timescale 1ns/1ps
`default_nettype none
module edrf_rx_model
(
    input  wire logic         mclk_in,      // clock
    input  wire logic         reset_in,     // sync reset
    input  wire logic         bit_tick_in,  // link bit pulse
    input  wire logic         line_in,      // serial line
    input  wire logic [9:0]   fixed_len_in, // agreed length, 0 ends on trailer
    output logic      [255:0] bits_out,     // last frame, first bit at 0
    output logic      [15:0]  len_out,      // bits in last frame
    output logic      [15:0]  cnt_out       // frames received
);
    logic [255:0] fr;   // frame under assembly
    int           n;    // bits gathered
    logic         act;  // inside a frame
    logic         done; // end of frame seen
    // ==========
    // one bit per tick; start bit opens, count or zero word closes
    // ==========
    always @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            act = 1'b0;
            cnt_out <= 16'h0;
        end
        else if (bit_tick_in && !act && line_in)
        begin
            act = 1'b1;
            fr = '0;
            fr[0] = 1'b1;
            n = 1;
        end
        else if (bit_tick_in && act && n < 256)
        begin
            fr[n] = line_in;
            n++;
            // a zero hit word would end early: trailer must be unique
            done = (fixed_len_in != 10'h0) ? (n == int'(fixed_len_in))
                 : (n >= 64 && n % 32 == 0 && fr[n-32 +: 32] == 32'h0);
            if (done)
            begin
                act = 1'b0;
                bits_out <= fr;
                len_out <= 16'(n);
                cnt_out <= cnt_out + 16'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the return link framer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    import edrf_pkg::*;
    logic         mclk_in = 1'b0;    // clock
    logic         reset_in = 1'b1;   // sync reset
    logic [3:0]   tcnt = 4'h0;       // link tick divider
    logic         trig_in = 1'b0;    // trigger accept
    logic         read_in = 1'b0;    // read-event
    logic         clear_in = 1'b0;   // clear-readout
    logic         rb_req_in = 1'b0;  // read-back request
    edrf_event_t  event_in = '0;     // event contents
    edrf_rb_t     rb_in = '0;        // read-back contents
    logic [9:0]   fixed_len = 10'h0; // agreed frame length
    logic         line_out;          // serial line
    logic         busy_out;          // frame running
    logic         full_out;          // buffers full
    logic         pending_out;       // request waiting
    logic [2:0]   occupancy_out;     // buffered events
    logic [255:0] rx_bits;           // received frame
    logic [15:0]  rx_len;            // received length
    logic [15:0]  rx_cnt;            // frames received
    int           err_count = 0;     // mismatches
    int           cmp_count = 0;     // comparisons
    // ==========
    // clock, link ticks every 2 cycles, slot every 16
    // ==========
    initial
    begin
        forever #4 mclk_in = ~mclk_in;
    end
    always_ff @(posedge mclk_in)
        tcnt <= tcnt + 4'h1;
    edrf_framer DUT (.mclk_in(mclk_in), .reset_in(reset_in), .bit_tick_in(tcnt[0]),
        .frame_slot_in(tcnt == 4'h1), .trig_in(trig_in), .event_in(event_in),
        .read_in(read_in), .clear_in(clear_in), .rb_req_in(rb_req_in), .rb_in(rb_in),
        .err_in(3'h5), .serial_in(8'ha7), .line_out(line_out), .busy_out(busy_out),
        .occupancy_out(occupancy_out), .full_out(full_out), .pending_out(pending_out));
    edrf_rx_model u_rx (.mclk_in(mclk_in), .reset_in(reset_in), .bit_tick_in(tcnt[0]),
        .line_in(line_out), .fixed_len_in(fixed_len), .bits_out(rx_bits),
        .len_out(rx_len), .cnt_out(rx_cnt));
    // ==========
    // access tasks
    // ==========
    task automatic pulse(input int w);
        @(posedge mclk_in);
        trig_in <= (w == 0);
        read_in <= (w == 1);
        clear_in <= (w == 2);
        rb_req_in <= (w == 3);
        @(posedge mclk_in);
        {trig_in, read_in, clear_in, rb_req_in} <= 4'h0;
    endtask
    // the far end spaces triggers and their reads by 2.2 us
    task automatic trig(input edrf_event_t e);
        event_in <= e;
        pulse(0);
        repeat (275) @(posedge mclk_in);
    endtask
    function automatic edrf_event_t mk(input int k);
        edrf_event_t e;
        e = '0;
        e.tag = 5'(k + 3);
        e.ttime = 5'(k + 16);
        e.nhits = 3'((k + 4) % 5);
        for (int i = 0; i < 4; i++)
            e.hits[i] = {8'(k + 1), 8'(i + 1), 16'hc3a5};
        return e;
    endfunction
    function automatic logic [31:0] hdr(input logic k, input logic [4:0] t,
        input logic [4:0] a, input logic [1:0] ix, input logic [2:0] oc);
        edrf_hdr_t h;
        h = '0;
        h.start = START_BIT;
        h.kind = k;
        h.tag_f = t;
        h.time_f = a;
        h.err = 3'h5;
        h.serial = 8'ha7;
        h.spare = {3'h0, oc, ix};
        return h;
    endfunction
    task automatic chk_frame(input logic [255:0] f, input logic [15:0] n);
        logic [15:0] c0;
        c0 = rx_cnt;
        for (int i = 0; i < 1000 && rx_cnt == c0; i++)
            @(posedge mclk_in);
        // a frame that never arrives counts as a mismatch
        `CHK(rx_cnt != c0, 1'b1)
        `CHK(rx_len, n)
        `CHK(rx_bits, f)
    endtask
    task automatic chk_evt(input edrf_event_t e, input logic [1:0] ix, input logic [2:0] oc);
        logic [255:0] f;
        f = '0;
        f[31:0] = hdr(TYPE_EVT, e.tag, e.ttime, ix, oc);
        for (int i = 0; i < int'(e.nhits); i++)
            f[32*i+32 +: 32] = e.hits[i];
        chk_frame(f, 16'(32 * (int'(e.nhits) + 2)));
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk_in);
        err_count++;
        results();
    end
    // ==========
    // main sequence
    // ==========
    initial
    begin
        repeat (2) @(posedge mclk_in);
        reset_in <= 1'b0;
        @(posedge mclk_in);
        `CHK({line_out, busy_out, full_out, pending_out, occupancy_out}, 7'h0)
        pulse(1);
        repeat (40) @(posedge mclk_in);
        `CHK({pending_out, rx_cnt}, 17'h0)
        for (int k = 0; k < 4; k++)
            trig(mk(k));
        `CHK({full_out, occupancy_out}, 4'hc)
        // deliberate overrun: the design must drop it
        trig(mk(9));
        `CHK(occupancy_out, 3'h4)
        pulse(1);
        repeat (40) @(posedge mclk_in);
        // the far end's model sees a free level again before this trigger
        trig(mk(4));
        `CHK(occupancy_out, 3'h4)
        chk_evt(mk(0), 2'h0, 3'h4);
        for (int k = 1; k < 5; k++)
        begin
            pulse(1);
            chk_evt(mk(k), 2'(k % 4), 3'(5 - k));
        end
        `CHK({full_out, occupancy_out}, 4'h0)
        fixed_len <= 10'd96;
        rb_in <= {5'h1b, 5'h06, 64'h8421_5a5a_0f0f_3c3c};
        pulse(3);
        chk_frame({160'h0, 64'h8421_5a5a_0f0f_3c3c, hdr(TYPE_REG, 5'h1b, 5'h06, 2'h0, 3'h0)},
            16'd96);
        fixed_len <= 10'h0;
        trig(mk(1));
        trig(mk(2));
        pulse(2);
        @(posedge mclk_in);
        `CHK(occupancy_out, 3'h0)
        pulse(1);
        repeat (40) @(posedge mclk_in);
        `CHK({pending_out, busy_out}, 2'h0)
        trig(mk(3));
        pulse(1);
        chk_evt(mk(3), 2'h0, 3'h1);
        results();
    end
endmodule
`default_nettype wire
